/* File: include/etc_consts.svh */
`ifndef ETC_CONSTS_SVH
`define ETC_CONSTS_SVH
// op mode codes
`define ETC_MODE_NORMAL 2'h0
`define ETC_MODE_REPEAT 2'h1
`define ETC_MODE_BLOCK  2'h2
// unit size codes
`define ETC_SZ_BYTE 2'h0
`define ETC_SZ_WORD 2'h1
`define ETC_SZ_LONG 2'h2
// mode byte a field positions
`define ETC_MA_MODE_HI 7
`define ETC_MA_MODE_LO 6
`define ETC_MA_SZ_HI   5
`define ETC_MA_SZ_LO   4
`define ETC_MA_SM_HI   3
`define ETC_MA_SM_LO   2
// mode byte b field positions
`define ETC_MB_CHAIN_ON   7
`define ETC_MB_CHAIN_COND 6
`define ETC_MB_IRQ_SEL    5
`define ETC_MB_AREA_SIDE  4
`define ETC_MB_DM_HI      3
`define ETC_MB_DM_LO      2
// register bus offsets of the directly reachable registers
`define ETC_OFS_ENABLE  4'h0
`define ETC_OFS_CONTROL 4'h1
`define ETC_OFS_VBASE   4'h2
// control register bit positions
`define ETC_CC_READ_SKIP 4
`define ETC_CC_STOP      0
// reset values
`define ETC_RST_ENABLE  16'h0000
`define ETC_RST_CONTROL 8'h00
`define ETC_RST_VBASE   32'h00000000
// vector base writable mask, bits 27..12
`define ETC_VBASE_MASK  32'h0ffff000
`endif

/* File: include/etc_pkg.sv */
// Purpose: types shared by the event transfer controller
// Assumes: constants in etc_consts.svh
// Notes:   descriptor is carried as one packed struct
package etc_pkg;
  typedef struct packed {
    logic [7:0]  mode_a;       // descriptor_mode_a
    logic [7:0]  mode_b;       // descriptor_mode_b
    logic [31:0] src;          // descriptor_source_pointer
    logic [31:0] dst;          // descriptor_destination_pointer
    logic [15:0] cnt_a;        // descriptor_count_a
    logic [15:0] cnt_b;        // descriptor_block_count
  } etc_desc_t;
  // memory bus request bundle
  typedef struct packed {
    logic        req;
    logic        we;
    logic [31:0] addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } etc_mreq_t;
  typedef enum logic [3:0] {
    ETC_IDLE  = 4'h0,
    ETC_VEC   = 4'h1,
    ETC_RD    = 4'h3,
    ETC_SRD   = 4'h2,
    ETC_DWR   = 4'h6,
    ETC_STEP  = 4'h7,
    ETC_WB    = 4'h5,
    ETC_DONE  = 4'h4,
    ETC_NEXT  = 4'hc
  } etc_state_t;
endpackage

/* File: core/etc_core.sv */
`include "etc_consts.svh"
// Purpose: interrupt driven transfer controller core
// Assumes: memory answers with mem_ack; one 32 bit bus with byte enables
// Notes:   units with an unaligned destination are split into byte write cycles
//
// Summary of operation
// - vector read, descriptor read, then data move
// - write descriptor back to same place
// - mode 00 normal, 01 repeat, 10 block
// - size 00 byte, 01 word, 10 longword
// - source pointer fixed, up or down
// - destination pointer fixed, up or down
// - chain on bit continues with next descriptor
// - short mode uses low 24 address bits
// - misaligned destination units split into byte write cycles
// - normal count zero clears enable, interrupts
// - count zero means 65536 transfers
// - repeat low byte reloads from high byte
// - block low byte counts units, reloads
// - block counter zero clears enable, interrupts
// - block counter unused outside block mode
// - enable bit steers request to controller
// - enable bit cleared by write 0 after read 1
// - per transfer select clears enable each time
// - otherwise enable stays until count exhausted, in repeat mode always
// - descriptor is three or four longwords
// - read skip on repeated vector unless chained
// - address error or nmi stops, sticky flag
module etc_core
  import etc_pkg::*;
#(
  parameter int NSRC = 16
) (
  input  wire logic                clock,
  input  wire logic                rst_n,
  input  wire logic [NSRC-1:0]     irq_in,        // interrupt sources, level
  output logic      [NSRC-1:0]     cpu_irq,       // requests to processor
  input  wire logic                full_addr,     // 1 full, 0 short addressing
  input  wire logic                nmi,           // stops controller
  input  wire logic                addr_err,      // stops controller
  input  wire logic                reg_sel,       // register access strobe
  input  wire logic                reg_we,
  input  wire logic [3:0]          reg_addr,
  input  wire logic [31:0]         reg_wdata,
  output logic      [31:0]         reg_rdata,
  output etc_mreq_t                mem,
  input  wire logic                mem_ack,
  input  wire logic [31:0]         mem_rdata,
  output logic                     busy
);
  ////////////////////////////////////////////////////////////////
  // state
  etc_state_t        st_r, st_nxt;            // sequencer state
  etc_desc_t         d_r, d_nxt;              // working descriptor
  logic [NSRC-1:0]   en_r, en_nxt;            // source_activation_enable
  logic [NSRC-1:0]   seen_r, seen_nxt;        // bits read as one
  logic [NSRC-1:0]   cirq_r, cirq_nxt;        // cpu interrupt latch
  logic [7:0]        cc_r, cc_nxt;            // controller_control
  logic [31:0]       vb_r, vb_nxt;            // vector_base
  logic [31:0]       dadr_r, dadr_nxt;        // descriptor address
  logic [31:0]       dat_r, dat_nxt;          // unit data
  logic [3:0]        src_r, src_nxt;          // active source
  logic [3:0]        last_r, last_nxt;        // previous vector
  logic              lvld_r, lvld_nxt;        // previous vector valid
  logic              chn_r, chn_nxt;          // previous was chained
  logic [1:0]        idx_r, idx_nxt;          // longword / byte index
  logic              split_r, split_nxt;      // byte split active
  etc_mreq_t         mem_r, mem_nxt;
  logic [31:0]       rd_r, rd_nxt;

  ////////////////////////////////////////////////////////////////
  // helpers
  logic [2:0]  step;                          // unit size in bytes
  logic [1:0]  op;
  logic [1:0]  sz;
  logic [31:0] amask;
  logic [NSRC-1:0] act;
  logic [3:0]  pick;
  logic        any;
  logic [2:0]  nlw;                           // descriptor longwords

  always_comb begin
    op    = d_r.mode_a[`ETC_MA_MODE_HI:`ETC_MA_MODE_LO];
    sz    = d_r.mode_a[`ETC_MA_SZ_HI:`ETC_MA_SZ_LO];
    unique case (sz)
      `ETC_SZ_WORD: step = 3'h2;
      `ETC_SZ_LONG: step = 3'h4;
      default:      step = 3'h1;
    endcase
    amask = full_addr ? 32'hffffffff : 32'h00ffffff;
    nlw   = full_addr ? 3'h4 : 3'h3;
    act   = irq_in & en_r;
    any   = |act;
    pick  = 4'h0;
    for (int i = NSRC-1; i >= 0; i--) begin
      if (act[i]) begin
        pick = 4'(i);
      end
    end
  end

  // unaligned check per pointer
  function automatic logic misal(input logic [31:0] a, input logic [1:0] s);
    misal = (s != `ETC_SZ_BYTE && a[0]) || (s == `ETC_SZ_LONG && a[1]);
  endfunction

  // byte enable for aligned unit
  function automatic logic [3:0] ben(input logic [31:0] a, input logic [1:0] s);
    unique case (s)
      `ETC_SZ_LONG: ben = 4'hf;
      `ETC_SZ_WORD: ben = a[1] ? 4'hc : 4'h3;
      default:      ben = 4'h1 << a[1:0];
    endcase
  endfunction

  // pointer step
  function automatic logic [31:0] nptr(input logic [31:0] p, input logic [1:0] m,
                                       input logic [2:0] s);
    if (!m[1]) nptr = p;
    else if (m[0]) nptr = p - {29'h0, s};
    else nptr = p + {29'h0, s};
  endfunction

  ////////////////////////////////////////////////////////////////
  // sequencer next state
  always_comb begin
    logic        last_unit;
    logic        cnt_end;
    logic [7:0]  lo;
    logic        do_chain;
    logic [31:0] a;
    logic [31:0] rew;
    last_unit = 1'b0;
    cnt_end   = 1'b0;
    lo        = 8'h0;
    do_chain  = 1'b0;
    a         = 32'h0;
    rew       = 32'h0;
    st_nxt    = st_r;
    d_nxt     = d_r;
    en_nxt    = en_r;
    seen_nxt  = seen_r;
    cirq_nxt  = cirq_r & irq_in | (irq_in & ~en_r);   // held until the source drops
    cc_nxt    = cc_r;
    vb_nxt    = vb_r;
    dadr_nxt  = dadr_r;
    dat_nxt   = dat_r;
    src_nxt   = src_r;
    last_nxt  = last_r;
    lvld_nxt  = lvld_r;
    chn_nxt   = chn_r;
    idx_nxt   = idx_r;
    split_nxt = split_r;
    mem_nxt   = mem_r;
    rd_nxt    = 32'h0;
    // register read with side effects
    if (reg_sel && !reg_we) begin
      unique case (reg_addr)
        `ETC_OFS_ENABLE:  begin rd_nxt = 32'(en_r); seen_nxt = en_r; end
        `ETC_OFS_CONTROL: rd_nxt = {24'h0, cc_r};
        `ETC_OFS_VBASE:   rd_nxt = vb_r;
        default:          rd_nxt = 32'h0;
      endcase
    end
    if (reg_sel && reg_we) begin
      unique case (reg_addr)
        `ETC_OFS_ENABLE: begin
          // ones set, zeros clear only bits read as one
          en_nxt = reg_wdata[NSRC-1:0] | (en_r & ~(seen_r & ~reg_wdata[NSRC-1:0]));
        end
        `ETC_OFS_CONTROL: begin
          cc_nxt[`ETC_CC_READ_SKIP] = reg_wdata[`ETC_CC_READ_SKIP];
          if (!reg_wdata[`ETC_CC_STOP]) cc_nxt[`ETC_CC_STOP] = 1'b0;
        end
        `ETC_OFS_VBASE: vb_nxt = reg_wdata & `ETC_VBASE_MASK;
        default: ;
      endcase
    end
    if (nmi || addr_err) begin
      cc_nxt[`ETC_CC_STOP] = 1'b1;
    end
    mem_nxt.req = 1'b0;
    unique case (st_r)
      ETC_IDLE: if (any && !cc_r[`ETC_CC_STOP]) begin
        src_nxt = pick;
        if (cc_r[`ETC_CC_READ_SKIP] && lvld_r && last_r == pick && !chn_r)
          st_nxt = ETC_SRD;
        else begin
          st_nxt  = ETC_VEC;
          mem_nxt = '{1'b1, 1'b0, vb_r + {26'h0, pick, 2'b00}, 4'hf, 32'h0};
        end
        lvld_nxt = 1'b1;
        last_nxt = pick;
        idx_nxt  = 2'h0;
      end
      ETC_VEC: begin
        // keep the vector request standing until it is answered
        mem_nxt.req = 1'b1;
        if (mem_ack) begin
          dadr_nxt = {mem_rdata[31:2], 2'b00};
          mem_nxt  = '{1'b1, 1'b0, {mem_rdata[31:2], 2'b00}, 4'hf, 32'h0};
          st_nxt   = ETC_RD;
        end
      end
      ETC_RD: begin
        mem_nxt.req = 1'b1;
        if (mem_ack) begin
          unique case (idx_r)
            2'h0: begin
              d_nxt.mode_a = mem_rdata[31:24];
              if (full_addr) d_nxt.src = {d_r.src[31:24], 24'h0} & 32'h0;
              else d_nxt.src = {8'h0, mem_rdata[23:0]};
            end
            2'h1: if (full_addr) d_nxt.src = mem_rdata;
                  else begin d_nxt.mode_b = mem_rdata[31:24];
                             d_nxt.dst = {8'h0, mem_rdata[23:0]}; end
            2'h2: if (full_addr) begin d_nxt.mode_b = mem_rdata[31:24]; end
                  else begin d_nxt.cnt_a = mem_rdata[31:16];
                             d_nxt.cnt_b = mem_rdata[15:0]; end
            default: d_nxt.dst = mem_rdata;
          endcase
          if (full_addr && idx_r == 2'h3) begin
            d_nxt.cnt_a = d_r.cnt_a;
          end
          mem_nxt.addr = dadr_r + {28'h0, 2'(idx_r + 2'h1), 2'b00};
          idx_nxt = idx_r + 2'h1;
          if ({1'b0, idx_r} == nlw - 3'h1) begin
            st_nxt = ETC_SRD;
            mem_nxt.req = 1'b0;
          end
        end
      end
      ETC_SRD: begin
        // source read in one cycle; only the destination write is split into bytes
        a = d_r.src & amask;
        split_nxt = misal(d_r.dst & amask, sz);             // destination decides the split
        mem_nxt = '{1'b1, 1'b0, a, ben(a, sz), 32'h0};
        if (mem_r.req && mem_ack) begin
          dat_nxt = mem_rdata;
          mem_nxt.req = 1'b0;
          idx_nxt = 2'h0;
          st_nxt = ETC_DWR;
        end
      end
      ETC_DWR: begin
        a = (d_r.dst & amask) + (split_r ? {30'h0, idx_r} : 32'h0);
        mem_nxt = '{1'b1, 1'b1, a, misal(d_r.dst & amask, sz) ?
                   (4'h1 << a[1:0]) : ben(a, sz), dat_r};
        if (mem_r.req && mem_ack) begin
          mem_nxt.req = 1'b0;
          idx_nxt = idx_r + 2'h1;
          if (!misal(d_r.dst & amask, sz) || {1'b0, idx_r} == step - 3'h1)
            st_nxt = ETC_STEP;
        end
      end
      ETC_STEP: begin
        d_nxt.src = nptr(d_r.src, d_r.mode_a[`ETC_MA_SM_HI:`ETC_MA_SM_LO], step);
        d_nxt.dst = nptr(d_r.dst, d_r.mode_b[`ETC_MB_DM_HI:`ETC_MB_DM_LO], step);
        lo = d_r.cnt_a[7:0] - 8'h1;
        unique case (op)
          `ETC_MODE_REPEAT: begin
            d_nxt.cnt_a[7:0] = (lo == 8'h0) ? d_r.cnt_a[15:8] : lo;
            last_unit = 1'b1;
            cnt_end = (lo == 8'h0);
          end
          `ETC_MODE_BLOCK: begin
            d_nxt.cnt_a[7:0] = (lo == 8'h0) ? d_r.cnt_a[15:8] : lo;
            if (lo == 8'h0) begin
              d_nxt.cnt_b = d_r.cnt_b - 16'h1;
              last_unit = 1'b1;
              cnt_end = (d_r.cnt_b == 16'h1);
            end else begin
              // the non-block side keeps moving; block side repeats per block
              st_nxt = ETC_SRD;
            end
          end
          default: begin
            d_nxt.cnt_a = d_r.cnt_a - 16'h1;
            last_unit = 1'b1;
            cnt_end = (d_r.cnt_a == 16'h1);
          end
        endcase
        // area pointer returns to its start once the area is done
        if (op != `ETC_MODE_NORMAL && lo == 8'h0) begin
          rew = 32'(d_r.cnt_a[15:8] - 8'h1) * 32'(step);
          if (d_r.mode_b[`ETC_MB_AREA_SIDE]) begin
            if (d_r.mode_a[`ETC_MA_SM_HI])
              d_nxt.src = d_r.mode_a[`ETC_MA_SM_LO] ? d_r.src + rew : d_r.src - rew;
          end else if (d_r.mode_b[`ETC_MB_DM_HI]) begin
            d_nxt.dst = d_r.mode_b[`ETC_MB_DM_LO] ? d_r.dst + rew : d_r.dst - rew;
          end
        end
        if (last_unit) begin
          st_nxt = ETC_WB;
          idx_nxt = 2'h0;
          if ((cnt_end && op != `ETC_MODE_REPEAT) ||
              d_r.mode_b[`ETC_MB_IRQ_SEL]) begin
            en_nxt[src_r] = 1'b0;
            cirq_nxt[src_r] = 1'b1;
          end
          do_chain = d_r.mode_b[`ETC_MB_CHAIN_ON] &&
                     (!d_r.mode_b[`ETC_MB_CHAIN_COND] || cnt_end);
          chn_nxt = do_chain;
        end
      end
      ETC_WB: begin
        // store back in the read order
        mem_nxt.req = 1'b1;
        mem_nxt.we  = 1'b1;
        mem_nxt.be  = 4'hf;
        mem_nxt.addr = dadr_r + {28'h0, idx_r, 2'b00};
        unique case (idx_r)
          2'h0: mem_nxt.wdata = full_addr ? {d_r.mode_a, 24'h0} :
                                {d_r.mode_a, d_r.src[23:0]};
          2'h1: mem_nxt.wdata = full_addr ? d_r.src : {d_r.mode_b, d_r.dst[23:0]};
          2'h2: mem_nxt.wdata = full_addr ? {d_r.mode_b, 24'h0} : {d_r.cnt_a, d_r.cnt_b};
          default: mem_nxt.wdata = d_r.dst;
        endcase
        if (mem_r.req && mem_ack) begin
          idx_nxt = idx_r + 2'h1;
          mem_nxt.req = 1'b0;
          if ({1'b0, idx_r} == nlw - 3'h1) st_nxt = ETC_DONE;
        end
      end
      ETC_DONE: st_nxt = chn_r ? ETC_NEXT : ETC_IDLE;
      ETC_NEXT: begin
        // chained descriptor follows directly
        dadr_nxt = dadr_r + {27'h0, nlw, 2'b00};
        mem_nxt  = '{1'b1, 1'b0, dadr_r + {27'h0, nlw, 2'b00}, 4'hf, 32'h0};
        idx_nxt  = 2'h0;
        st_nxt   = ETC_RD;
      end
      default: st_nxt = ETC_IDLE;
    endcase
    if (cc_nxt[`ETC_CC_STOP] && !cc_r[`ETC_CC_STOP]) begin
      st_nxt = ETC_IDLE;
      mem_nxt.req = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_r <= ETC_IDLE; d_r <= '0; en_r <= NSRC'(`ETC_RST_ENABLE);
      seen_r <= '0; cirq_r <= '0; cc_r <= `ETC_RST_CONTROL;
      vb_r <= `ETC_RST_VBASE; dadr_r <= '0; dat_r <= '0; src_r <= '0;
      last_r <= '0; lvld_r <= 1'b0; chn_r <= 1'b0; idx_r <= '0;
      split_r <= 1'b0; mem_r <= '0; rd_r <= '0;
    end else begin
      st_r <= st_nxt; d_r <= d_nxt; en_r <= en_nxt;
      seen_r <= seen_nxt; cirq_r <= cirq_nxt; cc_r <= cc_nxt;
      vb_r <= vb_nxt; dadr_r <= dadr_nxt; dat_r <= dat_nxt; src_r <= src_nxt;
      last_r <= last_nxt; lvld_r <= lvld_nxt; chn_r <= chn_nxt; idx_r <= idx_nxt;
      split_r <= split_nxt; mem_r <= mem_nxt; rd_r <= rd_nxt;
    end
  end

  assign mem       = mem_r;
  assign reg_rdata = rd_r;
  assign cpu_irq   = cirq_r;
  assign busy      = (st_r != ETC_IDLE);
endmodule

/* File: tb/etc_mem_model.sv */
// Purpose: system memory seen by the controller's bus
// Assumes: 1 KB of longwords, ack registered
// Notes:   slow adds wait cycles; idle read data toggles
module etc_mem_model
  import etc_pkg::*;
(
  input  wire logic      clock,
  input  wire logic      rst_n,
  input  wire etc_mreq_t mem,
  input  wire logic      slow,
  output logic           mem_ack,
  output logic [31:0]    mem_rdata
);
  logic [31:0] ram [0:255]; // longword store
  logic [2:0]  wait_r;      // wait cycles spent on this request
  logic [31:0] idle_r;      // junk shown when not answering
  // answer after 0 or 3 waits, one ack per request
  always_ff @(posedge clock) begin
    idle_r <= rst_n ? ~idle_r : 32'h5a5a5a5a;
    if (!rst_n || !mem.req || mem_ack) begin
      mem_ack <= 1'b0;
      wait_r  <= 3'h0;
    end else if (wait_r >= (slow ? 3'h3 : 3'h0)) begin
      mem_ack <= 1'b1;
    end else begin
      wait_r <= wait_r + 3'h1;
    end
    // byte lanes written at the acknowledging edge
    if (mem.req && mem.we && mem_ack) begin
      for (int b = 0; b < 4; b++) begin
        if (mem.be[b]) ram[mem.addr[9:2]][8*b +: 8] <= mem.wdata[8*b +: 8];
      end
    end
  end
  assign mem_rdata = mem_ack ? ram[mem.addr[9:2]] : idle_r;
endmodule

/* File: tb/etc_core_checker.sv */
`include "etc_consts.svh"
// Purpose: port checks of the transfer controller
// Assumes: one clock, synchronous low reset
// Notes:   bound to etc_core below
module etc_core_checker
  import etc_pkg::*;
#(
  parameter int NSRC = 16
) (
  input wire logic            clock,
  input wire logic            rst_n,
  input wire logic [NSRC-1:0] irq_in,
  input wire logic [NSRC-1:0] cpu_irq,
  input wire logic            nmi,
  input wire logic            reg_sel,
  input wire logic            reg_we,
  input wire logic [3:0]      reg_addr,
  input wire logic [31:0]     reg_rdata,
  input wire etc_mreq_t       mem,
  input wire logic            mem_ack,
  input wire logic            busy
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  // a register read strobe
  sequence s_reg_rd(logic [3:0] a);
    reg_sel && !reg_we && reg_addr == a;
  endsequence
  // a read request shortly after start
  sequence s_rd_req;
    ##[0:3] (mem.req && !mem.we);
  endsequence
  property p_req_hold;
    mem.req && !mem_ack |=> mem.req && $stable(mem.addr) && $stable(mem.wdata);
  endproperty
  property p_req_busy;
    mem.req |-> busy;
  endproperty
  property p_start_vec;
    $rose(busy) |-> s_rd_req;
  endproperty
  property p_nmi_stop;
    nmi |=> (!busy)[*3];
  endproperty
  property p_unmapped;
    reg_sel && !reg_we && reg_addr > 4'h2 |=> reg_rdata == 32'h0;
  endproperty
  property p_vbase_bits;
    s_reg_rd(`ETC_OFS_VBASE) |=> (reg_rdata & ~`ETC_VBASE_MASK) == 32'h0;
  endproperty
  property p_ctrl_resv;
    s_reg_rd(`ETC_OFS_CONTROL) |=> reg_rdata[31:5] == 27'h0 && reg_rdata[2:1] == 2'h0;
  endproperty
  property p_irq_src;
    |cpu_irq |-> (cpu_irq & ~$past(irq_in)) == '0;
  endproperty
  property p_be_some;
    mem.req |-> mem.be != 4'h0;
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("bus request moved before ack");
  a_req_busy: assert property (p_req_busy) else $error("bus request while idle");
  a_start_vec: assert property (p_start_vec) else $error("no read opens a run");
  a_nmi_stop: assert property (p_nmi_stop) else $error("busy after nmi");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_vbase_bits: assert property (p_vbase_bits) else $error("fixed base bits set");
  a_ctrl_resv: assert property (p_ctrl_resv) else $error("reserved bits set");
  a_irq_src: assert property (p_irq_src) else $error("cpu irq without source");
  a_be_some: assert property (p_be_some) else $error("request with no lanes");
endmodule
bind etc_core etc_core_checker #(.NSRC(NSRC)) u_chk (.clock(clock), .rst_n(rst_n),
  .irq_in(irq_in), .cpu_irq(cpu_irq), .nmi(nmi), .reg_sel(reg_sel), .reg_we(reg_we),
  .reg_addr(reg_addr), .reg_rdata(reg_rdata), .mem(mem), .mem_ack(mem_ack), .busy(busy));

/* File: tb/tb_interrupt_driven_transfer_controller.sv */
`include "etc_consts.svh"
// Purpose: self-checking bench of the transfer controller
// Assumes: short addressing, vector base 0, source 3
// Notes:   descriptor at 0x100, data at 0x200 and 0x300
module tb_interrupt_driven_transfer_controller;
  import etc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic [15:0] irq_in = 16'h0;
  logic [15:0] cpu_irq;
  logic        nmi = 1'b0;
  logic        slow = 1'b0;  // memory wait mode
  logic        reg_sel = 1'b0;
  logic        reg_we = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata;
  logic [31:0] mem_rdata;
  logic [31:0] t;             // read-back value
  logic        mem_ack;
  logic        busy;
  etc_mreq_t   mem;
  int          num_errors = 0;
  int          n_compared = 0;
  int          cycles = 0;
  always #5 clock = ~clock;
  etc_core #(.NSRC(16)) u_dut (.clock(clock), .rst_n(rst_n), .irq_in(irq_in),
    .cpu_irq(cpu_irq), .full_addr(1'b0), .nmi(nmi), .addr_err(1'b0), .reg_sel(reg_sel),
    .reg_we(reg_we), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .mem(mem), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .busy(busy));
  etc_mem_model u_mem (.clock(clock), .rst_n(rst_n), .mem(mem), .slow(slow),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  ////////////////////////////////////////
  task automatic close_out();
    if (num_errors == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // one-cycle register write
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(negedge clock);
    reg_sel = 1'b1;
    reg_we = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clock);
    reg_sel = 1'b0;
    reg_we = 1'b0;
  endtask
  // read strobe, data taken a cycle later
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(negedge clock);
    reg_sel = 1'b1;
    reg_addr = a;
    @(negedge clock);
    reg_sel = 1'b0;
    d = reg_rdata;
  endtask
  // activate source 3 through its enable bit, wait out the run
  task automatic run(input bit keep);
    int i;
    rd(`ETC_OFS_ENABLE, t);
    wr(`ETC_OFS_ENABLE, 32'h8);
    irq_in[3] = 1'b1;
    for (i = 0; i < 50 && busy !== 1'b1; i++) @(negedge clock);
    if (!keep) irq_in[3] = 1'b0;
    for (i = 0; i < 400 && busy !== 1'b0; i++) @(negedge clock);
    chk({31'h0, busy}, 32'h0);
  endtask
  // build descriptor, run, check writeback, enable and cpu request
  task automatic scen(input logic [7:0] ma, mb, input logic [31:0] c, input bit keep,
                      input logic [31:0] es, ed, ec, input logic [15:0] en, irq);
    u_mem.ram[64] = {ma, 24'h000200};
    u_mem.ram[65] = {mb, 24'h000300};
    u_mem.ram[66] = c;
    run(keep);
    chk(u_mem.ram[64], {ma, es[23:0]});
    chk(u_mem.ram[65], {mb, ed[23:0]});
    chk(u_mem.ram[66], ec);
    rd(`ETC_OFS_ENABLE, t);
    chk(t, {16'h0, en});
    chk({16'h0, cpu_irq}, {16'h0, irq});
    irq_in[3] = 1'b0;
    repeat (3) @(negedge clock);
  endtask
  ////////////////////////////////////////
  // hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 6000) begin
      num_errors++;
      close_out();
    end
  end
  initial begin
    repeat (4) @(negedge clock);
    rst_n = 1'b1;
    u_mem.ram[3] = 32'h00000100;
    u_mem.ram[128] = 32'h12345678;
    for (int a = 0; a < 6; a++) begin
      rd(a[3:0], t);
      chk(t, 32'h0);
    end
    wr(`ETC_OFS_VBASE, 32'hffffffff);
    rd(`ETC_OFS_VBASE, t);
    chk(t, `ETC_VBASE_MASK);
    wr(`ETC_OFS_VBASE, 32'h0);
    // longword normal, last transfer
    scen(8'h28, 8'h08, 32'h00010000, 1, 32'h204, 32'h304, 32'h0, 16'h0, 16'h8);
    chk(u_mem.ram[192], 32'h12345678);
    slow = 1'b1;
    // word down-count, more to go
    scen(8'h1c, 8'h0c, 32'h00020000, 0, 32'h1fe, 32'h2fe, 32'h00010000, 16'h8, 16'h0);
    slow = 1'b0;
    // byte fixed, per-transfer cpu request
    scen(8'h00, 8'h20, 32'h00050000, 1, 32'h200, 32'h300, 32'h00040000, 16'h0, 16'h8);
    // repeat reload, block counter untouched
    scen(8'h48, 8'h00, 32'h03011234, 0, 32'h201, 32'h300, 32'h03031234, 16'h8, 16'h0);
    slow = 1'b1;
    // block of two bytes, last block
    scen(8'h88, 8'h00, 32'h02020001, 1, 32'h202, 32'h300, 32'h02020000, 16'h0, 16'h8);
    @(negedge clock);
    nmi = 1'b1;
    @(negedge clock);
    nmi = 1'b0;
    rd(`ETC_OFS_CONTROL, t);
    chk(t, 32'h1);
    rd(`ETC_OFS_ENABLE, t);
    wr(`ETC_OFS_ENABLE, 32'h8);
    irq_in[3] = 1'b1;
    repeat (20) begin
      @(negedge clock);
      chk({31'h0, busy}, 32'h0);
    end
    irq_in[3] = 1'b0;
    wr(`ETC_OFS_CONTROL, 32'h0);
    rd(`ETC_OFS_CONTROL, t);
    chk(t, 32'h0);
    rd(`ETC_OFS_ENABLE, t);
    chk(t, 32'h8);
    wr(`ETC_OFS_ENABLE, 32'h0);
    rd(`ETC_OFS_ENABLE, t);
    chk(t, 32'h0);
    close_out();
  end
endmodule
